// ==== src/lcdsc_driver.sv ====
// Segment and common scan driver with display memory and control register
//
// Overview of operation
// - Drive 32 segments by 4 commons
// - Display memory is page 2 bytes 00H-0FH
// - Bit one lights dot, zero leaves off
// - Fetch memory autonomously in step with frame clock
// - Unused display bytes stay general-purpose storage
// - Refresh continues from subsidiary clock during idle
// - Frame rate is frame clock over commons
// - Control selects on, duty, clock, resistors
// - Reset clears control: blank, quarter, 64Hz
// - Frame clock sets common scan rate
// - Duty selects which commons are active
// - Segments present bit per active common phase
// - One selects, zero gives non-select level
// - No watch timer; its run and clock come in as inputs
`timescale 1ns/100ps
`include "lcdsc_defines.svh"

module lcdsc_driver #(
  parameter int SEGMENTS = `LCDSC_SEGMENTS,
  parameter int COMMONS  = `LCDSC_COMMONS,
  parameter int RAM_BYTES = `LCDSC_RAM_BYTES
) (
  input  wire logic                 mclk_in,
  input  wire logic                 rst_b_in,
  input  wire lcdsc_pkg::lcdsc_bus_t bus_in,
  input  wire logic                 watch_run_in,
  input  wire logic                 watch_clock_in,
  output logic [7:0]                bus_rdata_out,
  output logic                      bus_hit_out,
  output logic [SEGMENTS-1:0]       segment_outputs_out,
  output logic [COMMONS-1:0]        common_outputs_out,
  output logic                      ext_resistor_out,
  output logic                      half_bias_out,
  output logic                      frame_clock_out
);

  typedef enum logic [1:0] {
    LCDSC_PH0,
    LCDSC_PH1,
    LCDSC_PH2,
    LCDSC_PH3
  } lcdsc_phase_t;

  lcdsc_pkg::lcdsc_ctrl_t ctrl_reg;
  logic [7:0]             ram_mem [RAM_BYTES];
  logic [2:0]             div_reg;
  lcdsc_phase_t           phase_reg;
  logic [7:0]             rdata_reg;
  logic                   hit_reg;
  logic [SEGMENTS-1:0]    seg_reg;
  logic [COMMONS-1:0]     com_reg;
  logic                   frame_reg;

  // Address decode
  wire ram_hit  = !bus_in.sfr && bus_in.page == `LCDSC_RAM_PAGE &&
                  bus_in.addr <= `LCDSC_RAM_LAST;
  wire ctrl_hit = bus_in.sfr && bus_in.addr == `LCDSC_CTRL_OFFSET;
  wire [3:0] ram_idx = bus_in.addr[3:0];
  wire ram_wr  = ram_hit && bus_in.wr;
  wire ctrl_wr = ctrl_hit && bus_in.wr;

  // Frame clock divider from the watch clock enable
  logic [2:0] div_mask;
  always_comb begin
    unique case (ctrl_reg.clk_sel)
      `LCDSC_CLK_64HZ:  div_mask = `LCDSC_DIV_64HZ;
      `LCDSC_CLK_128HZ: div_mask = `LCDSC_DIV_128HZ;
      `LCDSC_CLK_256HZ: div_mask = `LCDSC_DIV_256HZ;
      `LCDSC_CLK_512HZ: div_mask = `LCDSC_DIV_512HZ;
    endcase
  end
  // Watch timer stopped means no edges reach the divider
  wire wtick = watch_run_in && watch_clock_in;
  wire frame_tick = wtick && ((div_reg & div_mask) == div_mask);
  wire [2:0] div_next = frame_tick ? 3'h0 : div_reg + 3'h1;

  // Common scan sequence
  logic [1:0] last_phase;
  always_comb begin
    unique case (ctrl_reg.duty)
      `LCDSC_DUTY_QUARTER: last_phase = `LCDSC_LAST_QUARTER;
      `LCDSC_DUTY_THIRD:   last_phase = `LCDSC_LAST_THIRD;
      `LCDSC_DUTY_HALF:    last_phase = `LCDSC_LAST_HALF;
      `LCDSC_DUTY_STATIC:  last_phase = `LCDSC_LAST_STATIC;
    endcase
  end
  // Greater-or-equal recovers cleanly if duty shrinks mid-frame
  wire [1:0] phase_cur  = phase_reg;
  wire [1:0] phase_next = (phase_cur >= last_phase) ? 2'h0
                          : phase_cur + 2'h1;
  // One-hot common select; commons past the duty's last phase stay idle
  wire [COMMONS-1:0] com_scan;
  for (genvar c = 0; c < COMMONS; c++) begin : g_com
    localparam logic [1:0] IDX = 2'(c);
    assign com_scan[c] = (phase_next == IDX) && (IDX <= last_phase);
  end

  // Segment bits fetched straight from display memory
  wire [SEGMENTS-1:0] seg_fetch;
  for (genvar j = 0; j < SEGMENTS; j++) begin : g_seg
    localparam logic ODD = logic'(j % 2);
    wire [7:0] byte_w = ram_mem[j / 2];
    wire [2:0] bit_sel = {ODD, phase_next};
    assign seg_fetch[j] = byte_w[bit_sel];
  end

  // Reserved control bits are dropped on write and read back as zero
  wire [7:0] rd_sel = ram_hit  ? ram_mem[ram_idx] :
                      ctrl_hit ? {2'h0, ctrl_reg[5:0]} : 8'h00;

  // Next values; the clocked processes below only load them
  lcdsc_pkg::lcdsc_ctrl_t ctrl_wdata;
  lcdsc_pkg::lcdsc_ctrl_t ctrl_next;
  assign ctrl_wdata = lcdsc_pkg::lcdsc_ctrl_t'({2'h0, bus_in.wdata[5:0]});
  assign ctrl_next  = ctrl_wr ? ctrl_wdata : ctrl_reg;
  wire [7:0]          rdata_next     = bus_in.rd ? rd_sel : 8'h00;
  wire                hit_next       = bus_in.rd && (ram_hit || ctrl_hit);
  wire                half_bias_next = ctrl_reg.duty == `LCDSC_DUTY_HALF;

  // Display off blanks at once; on waits for the next frame tick
  wire                disp_on  = ctrl_reg.display_on;
  wire [SEGMENTS-1:0] seg_hold = frame_tick ? seg_fetch : seg_reg;
  wire [COMMONS-1:0]  com_hold = frame_tick ? com_scan : com_reg;
  wire [SEGMENTS-1:0] seg_next = disp_on ? seg_hold : {SEGMENTS{1'b0}};
  wire [COMMONS-1:0]  com_next = disp_on ? com_hold : {COMMONS{1'b0}};

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= lcdsc_pkg::lcdsc_ctrl_t'(`LCDSC_CTRL_RESET);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Display memory is plain storage, no reset
  always_ff @(posedge mclk_in) begin
    if (ram_wr) begin
      ram_mem[ram_idx] <= bus_in.wdata;
    end
  end

  // Read answers stand one cycle, then fall back to zero
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= hit_next;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_reg <= 3'h0;
    end else if (wtick) begin
      div_reg <= div_next;
    end
  end

  // Pulse trails the tick by one cycle, level with the new outputs
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      frame_reg <= 1'b0;
    end else begin
      frame_reg <= frame_tick;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_reg <= LCDSC_PH3;
    end else if (frame_tick) begin
      phase_reg <= lcdsc_phase_t'(phase_next);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      seg_reg <= '0;
    end else begin
      seg_reg <= seg_next;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      com_reg <= '0;
    end else begin
      com_reg <= com_next;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ext_resistor_out <= 1'b0;
    end else begin
      ext_resistor_out <= ctrl_reg.ext_resistor;
    end
  end

  // Static duty ignores bias, so only half duty asks for half bias
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      half_bias_out <= 1'b0;
    end else begin
      half_bias_out <= half_bias_next;
    end
  end

  assign bus_rdata_out       = rdata_reg;
  assign bus_hit_out         = hit_reg;
  assign segment_outputs_out = seg_reg;
  assign common_outputs_out  = com_reg;
  assign frame_clock_out     = frame_reg;

endmodule

// ==== src/lcdsc_defines.svh ====
// Offsets, field codes, reset values and counts for the segment LCD driver
`ifndef LCDSC_DEFINES_SVH
`define LCDSC_DEFINES_SVH

`define LCDSC_CTRL_OFFSET     8'hE0
`define LCDSC_CTRL_RESET      8'h00
`define LCDSC_RAM_PAGE        4'h2
`define LCDSC_RAM_FIRST       8'h00
`define LCDSC_RAM_LAST        8'h0F
`define LCDSC_RAM_BYTES       16
`define LCDSC_SEGMENTS        32
`define LCDSC_COMMONS         4

`define LCDSC_DUTY_QUARTER    2'h0
`define LCDSC_DUTY_THIRD      2'h1
`define LCDSC_DUTY_HALF       2'h2
`define LCDSC_DUTY_STATIC     2'h3

`define LCDSC_CLK_64HZ        2'h0
`define LCDSC_CLK_128HZ       2'h1
`define LCDSC_CLK_256HZ       2'h2
`define LCDSC_CLK_512HZ       2'h3

`define LCDSC_DIV_64HZ        3'h7
`define LCDSC_DIV_128HZ       3'h3
`define LCDSC_DIV_256HZ       3'h1
`define LCDSC_DIV_512HZ       3'h0

`define LCDSC_LAST_QUARTER    2'h3
`define LCDSC_LAST_THIRD      2'h2
`define LCDSC_LAST_HALF       2'h1
`define LCDSC_LAST_STATIC     2'h0

`endif

// ==== src/lcdsc_pkg.sv ====
// Types shared by the segment LCD driver
package lcdsc_pkg;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] reserved;
    logic [1:0] clk_sel;
    logic       ext_resistor;
    logic [1:0] duty;
    logic       display_on;
  } lcdsc_ctrl_t;

  // Processor access to data memory and control register space
  typedef struct packed {
    logic       sfr;
    logic [3:0] page;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } lcdsc_bus_t;

endpackage

// ==== test/lcdsc_sva.sv ====
// Port checker for the segment LCD driver
`timescale 1ns/100ps
module lcdsc_sva #(
  parameter int SEGMENTS = 32,
  parameter int COMMONS  = 4
) (
  input wire logic                  mclk_in,
  input wire logic                  rst_b_in,
  input wire lcdsc_pkg::lcdsc_bus_t bus_in,
  input wire logic                  watch_run_in,
  input wire logic                  watch_clock_in,
  input wire logic [7:0]            bus_rdata_out,
  input wire logic                  bus_hit_out,
  input wire logic [SEGMENTS-1:0]   segment_outputs_out,
  input wire logic [COMMONS-1:0]    common_outputs_out,
  input wire logic                  frame_clock_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  sequence ram_rd_s;
    bus_in.rd && !bus_in.sfr && bus_in.page == 4'h2 && bus_in.addr < 8'h10;
  endsequence
  one_common_a: assert property ($onehot0(common_outputs_out))
    else $error("commons");
  frame_cause_a: assert property (frame_clock_out |->
    $past(watch_run_in && watch_clock_in)) else $error("frame");
  scan_step_a: assert property (frame_clock_out
    && common_outputs_out != 0 && $past(common_outputs_out) != 0
    |-> common_outputs_out == 4'h1
    || common_outputs_out == $past(common_outputs_out) << 1)
    else $error("scan");
  frozen_idle_a: assert property (!watch_run_in && !bus_in.wr
    && !$past(bus_in.wr) |=> $stable(segment_outputs_out)
    && $stable(common_outputs_out)) else $error("frozen");
  change_tick_a: assert property ($changed(common_outputs_out)
    && common_outputs_out != 0 |-> frame_clock_out) else $error("tick");
  ram_hit_a: assert property (ram_rd_s |=> bus_hit_out)
    else $error("hit");
  idle_read_a: assert property (!bus_in.rd |=> !bus_hit_out
    && bus_rdata_out == 8'h00) else $error("idle read");
  ctl_read_a: assert property (bus_in.rd && bus_in.sfr
    && bus_in.addr == 8'hE0 |=> bus_hit_out && !bus_rdata_out[7:6])
    else $error("control read");
endmodule

bind lcdsc_driver lcdsc_sva #(.SEGMENTS(SEGMENTS), .COMMONS(COMMONS)) chk (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .bus_in(bus_in),
  .watch_run_in(watch_run_in), .watch_clock_in(watch_clock_in),
  .bus_rdata_out(bus_rdata_out), .bus_hit_out(bus_hit_out),
  .segment_outputs_out(segment_outputs_out),
  .common_outputs_out(common_outputs_out),
  .frame_clock_out(frame_clock_out));

// ==== test/lcdsc_panel.sv ====
// Glass model: each dot keeps the level seen under its common
`timescale 1ns/100ps
module lcdsc_panel (
  input  wire logic        mclk_in,
  input  wire logic [31:0] seg_in,
  input  wire logic [3:0]  com_in,
  output logic [127:0]     dots_out
);
  always @(posedge mclk_in)
    for (int c = 0; c < 4; c++)
      if (com_in[c])
        for (int j = 0; j < 32; j++) dots_out[4*j+c] <= seg_in[j];
endmodule

// ==== test/tb_top.sv ====
// Bench for the segment LCD driver
`timescale 1ns/100ps
module tb_top;
  logic                  mclk_in = 0, rst_b_in = 0, run = 0, wclk = 0;
  logic                  hit, ext, hb, frame, on = 0, rd_q = 0;
  logic [1:0]            ci = 2'h3, last = 2'h3;
  logic [3:0]            com;
  logic [7:0]            rdata, ram [16];
  logic [8:0]            q [$];
  logic [31:0]           seg, lf = 32'h04E1AF2D;
  logic [127:0]          dots, img;
  lcdsc_pkg::lcdsc_bus_t bus = '0;
  int                    n_mismatch = 0, checked = 0, nf = 0;
  lcdsc_driver DUT (.mclk_in, .rst_b_in, .bus_in(bus), .watch_run_in(run),
    .watch_clock_in(wclk), .bus_rdata_out(rdata), .bus_hit_out(hit),
    .segment_outputs_out(seg), .common_outputs_out(com),
    .ext_resistor_out(ext), .half_bias_out(hb), .frame_clock_out(frame));
  lcdsc_panel PNL (.mclk_in, .seg_in(seg), .com_in(com), .dots_out(dots));
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [127:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // Two cycles per access, so no strobe is set twice in one step
  task automatic acc(input logic s, w, input logic [7:0] a, d, e);
    bus = '{s, s ? 4'h0 : 4'h2, a, w, !w, d};
    if (!w) q.push_back({s ? a == 8'hE0 : a < 8'h10, e});
    step(1);
    bus.rd = 0;
    bus.wr = 0;
    step(1);
  endtask
  task automatic ctl(input logic [7:0] v);
    acc(1, 1, 8'hE0, v, 8'h00);
    on = v[0];
    last = 2'h3 - v[2:1];
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      wclk = 1;
      @(posedge mclk_in) #1 wclk = 0;
      step(2);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    if (rd_q) chk({hit, rdata}, q.pop_front());
    rd_q <= bus.rd;
    if (frame) begin
      nf++;
      ci = (ci >= last) ? 2'h0 : ci + 2'h1;
      for (int j = 0; j < 32; j++) img[j] = ram[j/2][(j%2)*4+ci];
      if (on) chk(com, 4'h1 << ci);
      if (on) chk(seg, img[31:0]);
    end
  end
  initial forever #10 mclk_in = ~mclk_in;
  initial begin
    #400000;
    n_mismatch++;
    conclude;
  end
  initial begin
    step(20);
    rst_b_in = 1;
    step(1);
    acc(1, 0, 8'hE0, 8'h00, 8'h00);
    chk({ext, hb}, 2'h0);
    for (int i = 0; i < 16; i++) begin
      lf = nxt(lf);
      ram[i] = lf[7:0];
      acc(0, 1, 8'(i), ram[i], 8'h00);
    end
    for (int i = 0; i < 16; i++) acc(0, 0, 8'(i), 8'h00, ram[i]);
    acc(0, 0, 8'h10, 8'h00, 8'h00);
    acc(1, 0, 8'hE1, 8'h00, 8'h00);
    ctl(8'hFF);
    acc(1, 0, 8'hE0, 8'h00, 8'h3F);
    chk({ext, hb}, 2'h2);
    ctl(8'h31);
    nf = 0;
    pulse(4);
    chk(nf, 0);
    run = 1;
    for (int k = 0; k < 4; k++) begin
      ctl(8'h01 | 8'(k << 4));
      nf = 0;
      pulse(16);
      chk(nf, 2 << k);
    end
    for (int d = 0; d < 4; d++) begin
      ctl(8'h31 | 8'(d << 1));
      pulse(8);
      chk(hb, d == 2);
      for (int j = 0; j < 128; j++) img[j] = ram[j/8][(j/4)%2*4+j%4];
      if (d == 0) chk(dots, img);
    end
    ctl(8'h30);
    pulse(1);
    chk(com, 4'h0);
    conclude;
  end
endmodule
